//--- verilog/exec_regs.svh
// Constants for the branch, skip, table-read, misc and add execution unit.
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// Program counter width and its page split.
`define PC_WIDTH        12
`define PC_RESET        12'h000
`define LAST_PAGE       4'hf

// Data memory locations with a special meaning.
`define PC_LOW_ADDR     8'h06
`define TBL_PTR_ADDR    8'h07

// APB register byte offsets.
`define REG_STATUS      8'h00
`define REG_PC_TABLE    8'h04
`define REG_CTRL        8'h08

// Control register fields and reset value.
`define CTRL_RUN_BIT    0
`define CTRL_WAKE_BIT   1
`define CTRL_RUN_RESET  1'b1

// Status and PC/table register field positions.
`define STAT_FLAGS_LSB  8
`define STAT_STATE_LSB  14
`define STAT_PD_BIT     16
`define PCT_TABLE_HIGH_REG_LSB    16

`endif

//--- verilog/exec_pkg.sv
// Types shared by the execution unit and its testbench.
package exec_pkg;

  typedef enum logic [4:0] {
    OP_NOP                       = 5'b00000,
    OP_JUMP                      = 5'b00001,
    OP_SKIP_ZERO                 = 5'b00010,
    OP_SKIP_ZERO_MOVE_ACC        = 5'b00011,
    OP_SKIP_BIT_CLEAR            = 5'b00100,
    OP_SKIP_BIT_SET              = 5'b00101,
    OP_INC_SKIP_ZERO             = 5'b00110,
    OP_INC_SKIP_ZERO_TO_ACCUM    = 5'b00111,
    OP_DEC_SKIP_ZERO_ACC         = 5'b01000,
    OP_CALL                      = 5'b01001,
    OP_RETURN                    = 5'b01010,
    OP_RETURN_IMM                = 5'b01011,
    OP_RETURN_FROM_INTERRUPT     = 5'b01100,
    OP_TABLE_READ_CURRENT_PAGE   = 5'b01101,
    OP_TABLE_READ_LAST_PAGE      = 5'b01110,
    OP_WATCHDOG_CLEAR            = 5'b01111,
    OP_WATCHDOG_PRECLEAR_A       = 5'b10000,
    OP_WATCHDOG_PRECLEAR_B       = 5'b10001,
    OP_NIBBLE_SWAP               = 5'b10010,
    OP_NIBBLE_SWAP_TO_ACC        = 5'b10011,
    OP_POWER_DOWN                = 5'b10100,
    OP_ADD_CARRY                 = 5'b10101,
    OP_ADD_CARRY_TO_MEM          = 5'b10110,
    OP_ADD                       = 5'b10111,
    OP_ADD_IMM                   = 5'b11000,
    OP_ADD_TO_MEM                = 5'b11001
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [7:0]  addr;
    logic [2:0]  bit_sel;
    logic [7:0]  imm;
    logic [11:0] target;
  } instr_t;

  typedef struct packed {
    logic overflow_flag;
    logic powerdown_flag;
    logic timeout_flag;
    logic aux_carry_flag;
    logic zero_flag;
    logic carry_flag;
  } status_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_WAIT  = 2'b01,
    ST_TABLE = 2'b10,
    ST_HALT  = 2'b11
  } state_t;

  typedef enum logic [1:0] {
    PRE_NONE = 2'b00,
    PRE_A    = 2'b01,
    PRE_B    = 2'b10
  } preclear_t;

endpackage : exec_pkg

//--- verilog/add8_flags.sv
// Eight-bit adder with carry, half-carry, signed overflow and zero outputs.
`timescale 1ns/1ns
`default_nettype none
module add8_flags (
  // Operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  // Result and flags
  output logic      [7:0] sum,
  output logic            carry,
  output logic            aux_carry,
  output logic            overflow,
  output logic            zero
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;

  assign low_sum   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign full_sum  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign sum       = full_sum[7:0];
  assign carry     = full_sum[8];
  // Half-carry is the carry out of bit 3 into bit 4.
  assign aux_carry = low_sum[4];
  // Signed overflow: both operands agree in sign and the result does not.
  assign overflow  = (a[7] == b[7]) && (full_sum[7] != a[7]);
  assign zero      = (full_sum[7:0] == 8'h00);
endmodule : add8_flags
`default_nettype wire

//--- verilog/pin_sync3.sv
// Three-stage pin synchroniser that accepts a change once two stages agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Pin and synchronised level
  input  wire logic pin,
  output logic      level
);
  logic meta_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q  <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q <= pin;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level = level_q;
endmodule : pin_sync3
`default_nettype wire

//--- verilog/mcu_branch_misc_add_exec.sv
// Execution unit for branch, skip, table-read, misc and add instructions.
// Functional notes
// - A skip that happens costs two cycles; no skip costs one.
// - Writing the program counter low byte always costs two cycles.
// - Timeout and power-down flags clear on a watchdog clear or after both pre-clears back to back.
// - Skip-zero-move copies the memory byte to the accumulator, skips if zero.
// - Bit-test skips look at one memory bit and leave all flags alone.
// - Increment-skip writes back the incremented byte and skips when it is zero.
// - Decrement-skip puts the decremented byte in the accumulator, skips if zero.
// - Jump, call and all returns take two cycles and touch no flags.
// - Return-immediate pops the return address and loads the literal.
// - Current-page table read splits a word into table-high and memory.
// - Last-page table read does the same from the final page.
// - Power-down stops execution in one cycle and updates both status flags.
// - Swap-to-accumulator exchanges nibbles into the accumulator, memory untouched.
// - Add-with-carry sums accumulator, memory and carry into the accumulator.
// - Add-with-carry-to-memory writes that sum back to memory.
// - Plain add puts accumulator plus memory into the accumulator.
// - Add-immediate puts accumulator plus literal into the accumulator.
// - Add-to-memory writes accumulator plus memory back to memory.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "exec_regs.svh"
module mcu_branch_misc_add_exec
  import exec_pkg::*;
#(
  parameter int MEM_DEPTH   = 256,
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Instruction stream
  input  wire logic        instr_valid,
  input  wire instr_t      instr,
  output logic             instr_ready,
  // Program memory read port, data sampled in the same cycle as the strobe
  output logic             prog_rd,
  output logic [11:0]      prog_addr,
  input  wire logic [14:0] prog_data,
  // Watchdog hardware
  input  wire logic        wdt_timeout,
  output logic             wdt_clear,
  // Wake-up pin and visible state
  input  wire logic        wake_pin,
  output logic [11:0]      pc,
  output logic [7:0]       accumulator,
  output var status_t      flags,
  output logic [6:0]       table_high_reg,
  output logic             powerdown,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam int AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
  localparam int SW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  if (MEM_DEPTH < 8 || MEM_DEPTH > 256) begin : g_mem_check
    $error("MEM_DEPTH must lie between 8 and 256");
  end
  if (STACK_DEPTH < 2) begin : g_stack_check
    $error("STACK_DEPTH must be at least 2");
  end

  logic [7:0]  mem_q [MEM_DEPTH];
  logic [11:0] stack_q [STACK_DEPTH];
  logic [SW-1:0] sp_q;
  logic [11:0] pc_q;
  logic [7:0]  accumulator_q;
  status_t     flags_q;
  logic [6:0]  table_high_reg_q;
  logic [7:0]  tbl_dst_q;
  state_t      state_q;
  state_t      state_d;
  preclear_t   last_pre_q;
  logic        skip_q;
  logic        ready_q;
  logic        powerdown_q;
  logic        prog_rd_q;
  logic [11:0] prog_addr_q;
  logic        wdt_clear_q;
  logic        run_en_q;
  logic        wake_sw_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  logic        wake_level;
  logic        take;
  logic        exec;
  logic        in_range;
  logic [7:0]  mem_rd;
  logic [7:0]  res;
  logic        wr_acc;
  logic        wr_mem;
  logic        arith;
  logic        skip_now;
  logic        jump;
  logic        push;
  logic        pop;
  logic        tbl_go;
  logic        halt_op;
  logic        pcl_wr;
  logic        two_cyc;
  logic        pair_done;
  logic [7:0]  tbl_ptr;
  logic [7:0]  add_b;
  logic        add_cin;
  logic [7:0]  add_sum;
  logic        add_c;
  logic        add_ac;
  logic        add_ov;
  logic        add_z;
  logic        carry_now;

  pin_sync3 u_wake_sync (
    .clk   (clk),
    .srst  (srst),
    .pin   (wake_pin),
    .level (wake_level)
  );

  add8_flags u_adder (
    .a         (accumulator_q),
    .b         (add_b),
    .cin       (add_cin),
    .sum       (add_sum),
    .carry     (add_c),
    .aux_carry (add_ac),
    .overflow  (add_ov),
    .zero      (add_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch and decode.
  assign take      = instr_valid & ready_q;
  assign exec      = take & ~skip_q;
  assign carry_now = flags_q.carry_flag;
  assign in_range  = ({1'b0, instr.addr} < 9'(MEM_DEPTH));
  assign tbl_ptr   = mem_q[`TBL_PTR_ADDR];
  assign add_b     = (instr.op == OP_ADD_IMM) ? instr.imm : mem_rd;
  assign add_cin   = ((instr.op == OP_ADD_CARRY) || (instr.op == OP_ADD_CARRY_TO_MEM)) &
                     carry_now;
  assign pcl_wr    = wr_mem & (instr.addr == `PC_LOW_ADDR);
  assign two_cyc   = jump | pop | pcl_wr;
  assign pair_done = ((instr.op == OP_WATCHDOG_PRECLEAR_A) && (last_pre_q == PRE_B)) ||
                     ((instr.op == OP_WATCHDOG_PRECLEAR_B) && (last_pre_q == PRE_A));

  always_comb begin
    if (instr.addr == `PC_LOW_ADDR) begin
      mem_rd = pc_q[7:0];
    end else if (in_range) begin
      mem_rd = mem_q[instr.addr[AW-1:0]];
    end else begin
      mem_rd = 8'h00;
    end
  end

  always_comb begin
    res      = 8'h00;
    wr_acc   = 1'b0;
    wr_mem   = 1'b0;
    arith    = 1'b0;
    skip_now = 1'b0;
    jump     = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    tbl_go   = 1'b0;
    halt_op  = 1'b0;
    case (instr.op)
      OP_JUMP: jump = 1'b1;
      OP_CALL: begin
        jump = 1'b1;
        push = 1'b1;
      end
      OP_RETURN, OP_RETURN_FROM_INTERRUPT: pop = 1'b1;
      OP_RETURN_IMM: begin
        pop    = 1'b1;
        res    = instr.imm;
        wr_acc = 1'b1;
      end
      OP_SKIP_ZERO: skip_now = (mem_rd == 8'h00);
      OP_SKIP_ZERO_MOVE_ACC: begin
        res      = mem_rd;
        wr_acc   = 1'b1;
        skip_now = (mem_rd == 8'h00);
      end
      OP_SKIP_BIT_CLEAR: skip_now = ~mem_rd[instr.bit_sel];
      OP_SKIP_BIT_SET:   skip_now = mem_rd[instr.bit_sel];
      OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_TO_ACCUM: begin
        res      = mem_rd + 8'h01;
        wr_mem   = (instr.op == OP_INC_SKIP_ZERO);
        wr_acc   = (instr.op == OP_INC_SKIP_ZERO_TO_ACCUM);
        skip_now = (mem_rd == 8'hff);
      end
      OP_DEC_SKIP_ZERO_ACC: begin
        res      = mem_rd - 8'h01;
        wr_acc   = 1'b1;
        skip_now = (mem_rd == 8'h01);
      end
      OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: tbl_go = 1'b1;
      OP_NIBBLE_SWAP, OP_NIBBLE_SWAP_TO_ACC: begin
        res    = {mem_rd[3:0], mem_rd[7:4]};
        wr_mem = (instr.op == OP_NIBBLE_SWAP);
        wr_acc = (instr.op == OP_NIBBLE_SWAP_TO_ACC);
      end
      OP_POWER_DOWN: halt_op = 1'b1;
      OP_ADD_CARRY, OP_ADD, OP_ADD_IMM: begin
        res    = add_sum;
        arith  = 1'b1;
        wr_acc = 1'b1;
      end
      OP_ADD_CARRY_TO_MEM, OP_ADD_TO_MEM: begin
        res    = add_sum;
        arith  = 1'b1;
        wr_mem = 1'b1;
      end
      default: res = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing: two-cycle instructions, table reads and power-down.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (exec && halt_op) begin
          state_d = ST_HALT;
        end else if (exec && tbl_go) begin
          state_d = ST_TABLE;
        end else if (exec && two_cyc) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT:  state_d = ST_RUN;
      ST_TABLE: state_d = ST_RUN;
      ST_HALT: begin
        if (wake_level || wake_sw_q) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q     <= ST_RUN;
      ready_q     <= 1'b0;
      skip_q      <= 1'b0;
      powerdown_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      ready_q     <= (state_d == ST_RUN) & run_en_q;
      powerdown_q <= (state_d == ST_HALT);
      if (take) begin
        // A discarded slot clears the pending skip and advances the program counter.
        skip_q <= exec & skip_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and return stack.
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_q <= `PC_RESET;
      sp_q <= '0;
    end else if (take) begin
      if (exec && jump) begin
        pc_q <= instr.target;
      end else if (exec && pop) begin
        pc_q <= stack_q[(sp_q == '0) ? SW'(STACK_DEPTH - 1) : sp_q - 1'b1];
        sp_q <= (sp_q == '0) ? SW'(STACK_DEPTH - 1) : sp_q - 1'b1;
      end else if (exec && pcl_wr) begin
        pc_q <= {pc_q[11:8], res};
      end else begin
        pc_q <= pc_q + 12'h001;
      end
      if (exec && push) begin
        // Nesting deeper than the stack wraps and overwrites the oldest entry.
        stack_q[sp_q] <= pc_q + 12'h001;
        sp_q          <= (sp_q == SW'(STACK_DEPTH - 1)) ? '0 : sp_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and data memory.
  always_ff @(posedge clk) begin
    if (srst) begin
      accumulator_q <= 8'h00;
    end else if (exec && wr_acc) begin
      accumulator_q <= res;
    end
  end

  always_ff @(posedge clk) begin
    if (exec && wr_mem && !pcl_wr && in_range) begin
      mem_q[instr.addr[AW-1:0]] <= res;
    end else if (state_q == ST_TABLE && {1'b0, tbl_dst_q} < 9'(MEM_DEPTH)) begin
      mem_q[tbl_dst_q[AW-1:0]] <= prog_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table read port.
  always_ff @(posedge clk) begin
    if (srst) begin
      prog_rd_q        <= 1'b0;
      prog_addr_q      <= 12'h000;
      tbl_dst_q        <= 8'h00;
      table_high_reg_q <= 7'h00;
    end else begin
      prog_rd_q <= exec & tbl_go;
      if (exec && tbl_go) begin
        tbl_dst_q <= instr.addr;
        if (instr.op == OP_TABLE_READ_LAST_PAGE) begin
          prog_addr_q <= {`LAST_PAGE, tbl_ptr};
        end else begin
          prog_addr_q <= {pc_q[11:8], tbl_ptr};
        end
      end
      if (state_q == ST_TABLE) begin
        table_high_reg_q <= prog_data[14:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and watchdog pre-clear pairing.
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_q     <= '0;
      last_pre_q  <= PRE_NONE;
      wdt_clear_q <= 1'b0;
    end else begin
      wdt_clear_q <= exec & ((instr.op == OP_WATCHDOG_CLEAR) | pair_done);
      if (exec) begin
        case (instr.op)
          OP_WATCHDOG_PRECLEAR_A: last_pre_q <= PRE_A;
          OP_WATCHDOG_PRECLEAR_B: last_pre_q <= PRE_B;
          default:                last_pre_q <= PRE_NONE;
        endcase
      end
      if (exec && arith) begin
        flags_q.carry_flag     <= add_c;
        flags_q.zero_flag      <= add_z;
        flags_q.aux_carry_flag <= add_ac;
        flags_q.overflow_flag  <= add_ov;
      end
      if (exec && (halt_op || pair_done || instr.op == OP_WATCHDOG_CLEAR)) begin
        flags_q.powerdown_flag <= halt_op;
      end
      // A timeout in the same cycle as a clear still shows.
      if (wdt_timeout) begin
        flags_q.timeout_flag <= 1'b1;
      end else if (exec && (halt_op || pair_done || instr.op == OP_WATCHDOG_CLEAR)) begin
        flags_q.timeout_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave; read data is valid with pready, writes land at completion.
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      run_en_q  <= `CTRL_RUN_RESET;
      wake_sw_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      wake_sw_q <= 1'b0;
      if (psel && penable && !pready_q) begin
        prdata_q  <= 32'h0000_0000;
        pslverr_q <= 1'b0;
        case (paddr)
          `REG_STATUS: begin
            prdata_q[7:0]                                <= accumulator_q;
            prdata_q[`STAT_FLAGS_LSB +: 6]               <= flags_q;
            prdata_q[`STAT_STATE_LSB +: 2]               <= state_q;
            prdata_q[`STAT_PD_BIT]                       <= (state_q == ST_HALT);
            pslverr_q                                    <= pwrite;
          end
          `REG_PC_TABLE: begin
            prdata_q[11:0]                               <= pc_q;
            prdata_q[`PCT_TABLE_HIGH_REG_LSB +: 7]                 <= table_high_reg_q;
            pslverr_q                                    <= pwrite;
          end
          `REG_CTRL: prdata_q[`CTRL_RUN_BIT]             <= run_en_q;
          default:   pslverr_q                           <= 1'b1;
        endcase
      end
      if (psel && penable && pready_q && pwrite && paddr == `REG_CTRL) begin
        run_en_q  <= pwdata[`CTRL_RUN_BIT];
        wake_sw_q <= pwdata[`CTRL_WAKE_BIT];
      end
    end
  end

  assign instr_ready    = ready_q;
  assign prog_rd        = prog_rd_q;
  assign prog_addr      = prog_addr_q;
  assign wdt_clear      = wdt_clear_q;
  assign pc             = pc_q;
  assign accumulator    = accumulator_q;
  assign flags          = flags_q;
  assign table_high_reg = table_high_reg_q;
  assign powerdown      = powerdown_q;
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_skip_taken;
    exec && skip_now;
  endsequence
  sequence s_pair_b_then_a;
    exec && instr.op == OP_WATCHDOG_PRECLEAR_A && last_pre_q == PRE_B;
  endsequence

  property p_skip_pending;
    s_skip_taken |=> skip_q;
  endproperty
  a_skip_pending: assert property (p_skip_pending) else $error("skip not armed");

  // A watchdog timeout may still set its flag while a slot is discarded.
  property p_skip_discard;
    skip_q && take |=> $stable(accumulator_q) && ($stable(flags_q) || $past(wdt_timeout)) &&
      !skip_q;
  endproperty
  a_skip_discard: assert property (p_skip_discard) else $error("skipped slot had effect");

  property p_two_cycle;
    exec && two_cyc && !tbl_go |=> !ready_q;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two-cycle op not stalled");

  property p_pair_clears;
    s_pair_b_then_a |=> !flags_q.powerdown_flag ##0 wdt_clear_q;
  endproperty
  a_pair_clears: assert property (p_pair_clears) else $error("pre-clear pair failed");

  property p_single_keeps;
    exec && instr.op == OP_WATCHDOG_PRECLEAR_A && last_pre_q != PRE_B
      |=> $stable(flags_q.powerdown_flag);
  endproperty
  a_single_keeps: assert property (p_single_keeps) else $error("lone pre-clear changed flag");

  property p_move_skip;
    exec && instr.op == OP_SKIP_ZERO_MOVE_ACC |=> accumulator_q == $past(mem_rd) &&
      skip_q == (accumulator_q == 8'h00);
  endproperty
  a_move_skip: assert property (p_move_skip) else $error("skip-zero-move wrong");

  property p_dec_acc;
    exec && instr.op == OP_DEC_SKIP_ZERO_ACC |=> accumulator_q == $past(mem_rd) - 8'h01;
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement result wrong");

  property p_ret_imm;
    exec && instr.op == OP_RETURN_IMM |=> accumulator_q == $past(instr.imm) ##1 ready_q;
  endproperty
  a_ret_imm: assert property (p_ret_imm) else $error("return-immediate wrong");

  property p_table;
    exec && tbl_go |=> prog_rd_q && !ready_q ##1 table_high_reg_q == $past(prog_data[14:8]);
  endproperty
  a_table: assert property (p_table) else $error("table read sequence wrong");

  property p_halt;
    exec && halt_op |=> powerdown && flags_q.powerdown_flag && !ready_q;
  endproperty
  a_halt: assert property (p_halt) else $error("power-down not entered");

  property p_adc;
    exec && instr.op == OP_ADD_CARRY |=> accumulator_q ==
      $past(accumulator_q) + $past(mem_rd) + {7'h00, $past(carry_now)};
  endproperty
  a_adc: assert property (p_adc) else $error("add-with-carry result wrong");

endmodule : mcu_branch_misc_add_exec
`default_nettype wire

//--- testbench/mcu_branch_misc_add_exec_test.sv
// Directed bench for the branch, skip, table-read, misc and add execution unit.
`timescale 1ns/1ns
`default_nettype none
module mcu_branch_misc_add_exec_test
  import exec_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, wdt_timeout = 1'b0, wake_pin = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [14:0] prog_data = 15'h0;
  instr_t      instr = '0;
  logic        instr_ready, prog_rd, wdt_clear, powerdown, pready, pslverr;
  logic [11:0] prog_addr, pc;
  logic [7:0]  accumulator;
  logic [6:0]  table_high_reg;
  status_t     flags;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [2:0]  bsel = 3'h0;

  always #50 clk = ~clk;

  mcu_branch_misc_add_exec i_mcu_branch_misc_add_exec (
    .clk(clk), .srst(srst), .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data),
    .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear), .wake_pin(wake_pin), .pc(pc),
    .accumulator(accumulator), .flags(flags), .table_high_reg(table_high_reg),
    .powerdown(powerdown), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Returns one edge after the take edge, so the take edge's updates are settled.
  task automatic exec(input op_t o, input logic [7:0] a, input logic [7:0] i,
                      input logic [11:0] t);
    instr_valid <= 1'b1;
    instr <= '{op: o, addr: a, bit_sel: bsel, imm: i, target: t};
    do @(posedge clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    @(posedge clk);
  endtask : exec

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    check(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic results;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check({flags, accumulator}, 14'h0);
    exec(OP_ADD_IMM, 8'h00, 8'h7f, 12'h0);
    exec(OP_ADD_IMM, 8'h00, 8'h01, 12'h0);
    check({flags, accumulator}, {6'b100100, 8'h80});
    exec(OP_ADD_IMM, 8'h00, 8'h80, 12'h0);
    check({flags, accumulator}, {6'b100011, 8'h00});
    $display("add immediate test done");
    prog_data <= 15'h2a3c;
    exec(OP_TABLE_READ_LAST_PAGE, 8'h20, 8'h00, 12'h0);
    check({prog_rd, prog_addr[11:8]}, 5'h1f);
    exec(OP_SKIP_ZERO_MOVE_ACC, 8'h20, 8'h00, 12'h0);
    check(table_high_reg, 7'h2a);
    check({flags, accumulator}, {6'b100011, 8'h3c});
    exec(OP_ADD_TO_MEM, 8'h20, 8'h00, 12'h0);
    check({flags, accumulator}, {6'b000100, 8'h3c});
    exec(OP_ADD, 8'h20, 8'h00, 12'h0);
    check({flags, accumulator}, {6'b100100, 8'hb4});
    exec(OP_ADD_IMM, 8'h00, 8'h80, 12'h0);
    exec(OP_ADD_CARRY, 8'h20, 8'h00, 12'h0);
    check({flags, accumulator}, {6'b100000, 8'had});
    $display("table read and add test done");
    // An all-ones byte wraps to zero, so the following add must be thrown away.
    prog_data <= 15'h00ff;
    exec(OP_TABLE_READ_LAST_PAGE, 8'h21, 8'h00, 12'h0);
    exec(OP_INC_SKIP_ZERO, 8'h21, 8'h00, 12'h0);
    exec(OP_ADD_IMM, 8'h00, 8'h55, 12'h0);
    check(accumulator, 8'had);
    exec(OP_ADD, 8'h21, 8'h00, 12'h0);
    check({flags, accumulator}, {6'b000000, 8'had});
    exec(OP_JUMP, 8'h00, 8'h00, 12'h123);
    check({pc, instr_ready, 1'b0, flags}, {12'h123, 8'h00});
    $display("skip and jump test done");
    // Swapping the program counter low byte 0x23 gives 0x32.
    exec(OP_NIBBLE_SWAP, 8'h06, 8'h00, 12'h0);
    check({pc, instr_ready}, {12'h132, 1'b0});
    exec(OP_CALL, 8'h00, 8'h00, 12'h200);
    exec(OP_RETURN_IMM, 8'h00, 8'h5a, 12'h0);
    check({pc, accumulator}, {12'h133, 8'h5a});
    bsel = 3'h3;
    exec(OP_SKIP_BIT_SET, 8'h20, 8'h00, 12'h0);
    exec(OP_ADD_IMM, 8'h00, 8'h01, 12'h0);
    check({flags, accumulator}, {6'b000000, 8'h5a});
    exec(OP_SKIP_BIT_CLEAR, 8'h20, 8'h00, 12'h0);
    exec(OP_ADD_IMM, 8'h00, 8'h01, 12'h0);
    check(accumulator, 8'h5b);
    exec(OP_DEC_SKIP_ZERO_ACC, 8'h21, 8'h00, 12'h0);
    check(accumulator, 8'hff);
    exec(OP_NIBBLE_SWAP_TO_ACC, 8'h20, 8'h00, 12'h0);
    check(accumulator, 8'h87);
    exec(OP_ADD_CARRY_TO_MEM, 8'h20, 8'h00, 12'h0);
    exec(OP_ADD, 8'h20, 8'h00, 12'h0);
    check({flags, accumulator}, {6'b000101, 8'h86});
    prog_data <= 15'h0042;
    exec(OP_TABLE_READ_LAST_PAGE, 8'h07, 8'h00, 12'h0);
    prog_data <= 15'h1155;
    exec(OP_TABLE_READ_CURRENT_PAGE, 8'h22, 8'h00, 12'h0);
    check({prog_rd, prog_addr}, {1'b1, 12'h142});
    exec(OP_ADD, 8'h22, 8'h00, 12'h0);
    check({table_high_reg, accumulator}, {7'h11, 8'hdb});
    $display("call, swap and bit skip test done");
    exec(OP_POWER_DOWN, 8'h00, 8'h00, 12'h0);
    check({powerdown, flags.powerdown_flag}, 2'b11);
    wake_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wake_pin <= 1'b0;
    check(powerdown, 1'b0);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    exec(OP_WATCHDOG_PRECLEAR_A, 8'h00, 8'h00, 12'h0);
    exec(OP_NOP, 8'h00, 8'h00, 12'h0);
    exec(OP_WATCHDOG_PRECLEAR_B, 8'h00, 8'h00, 12'h0);
    check({flags.timeout_flag, flags.powerdown_flag}, 2'b11);
    exec(OP_WATCHDOG_PRECLEAR_A, 8'h00, 8'h00, 12'h0);
    exec(OP_WATCHDOG_PRECLEAR_B, 8'h00, 8'h00, 12'h0);
    check({flags.timeout_flag, flags.powerdown_flag, wdt_clear}, 3'b001);
    $display("watchdog and power-down test done");
    apb(1'b0, 8'h00, 32'h0, 1'b0);
    check(rd[7:0], 8'hdb);
    apb(1'b0, 8'h0c, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h0, 1'b1);
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    check(rd[0], 1'b1);
    apb(1'b1, 8'h08, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    check({rd[0], instr_ready}, 2'b00);
    $display("register access test done");
    results();
  end
endmodule : mcu_branch_misc_add_exec_test
`default_nettype wire
